// ---- capture_buf_if.sv ----
// Interface between the channel and its capture buffer
`timescale 1ns/10ps
interface capture_buf_if #(parameter int WIDTH = 16);
    logic             push;
    logic [WIDTH-1:0] push_data;
    logic             pop;
    logic             clear;
    logic [WIDTH-1:0] head;
    logic             not_empty;
    logic             full;

    modport owner (output push, push_data, pop, clear, input head, not_empty, full);
    modport store (input push, push_data, pop, clear, output head, not_empty, full);
endinterface

// ---- capture_buffer.sv ----
// Small capture value store with registered head word
`timescale 1ns/10ps
module capture_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = capture_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic     clk,
    input wire logic     reset_n,
    // Buffer port
    capture_buf_if.store bus
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [WIDTH-1:0] head;

    wire do_pop  = bus.pop && (count != '0);
    wire do_push = bus.push && (count != (PW+1)'(DEPTH));
    wire [PW-1:0] next_rd = rd_ptr + 1'b1;

    assign bus.not_empty = (count != '0);
    assign bus.full      = (count == (PW+1)'(DEPTH));
    assign bus.head      = head;

    always_ff @(posedge clk)
    begin
        if (do_push)
            mem[wr_ptr] <= bus.push_data;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else if (bus.clear)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= next_rd;
            count <= count + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

    // Head register follows the oldest entry
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            head <= '0;
        else if (bus.clear)
            head <= '0;
        else if (do_pop && count > (PW+1)'(1))
            head <= mem[next_rd];
        else if (do_push && (count == '0 || (do_pop && count == (PW+1)'(1))))
            head <= bus.push_data;
        else
            head <= head;
    end
endmodule

// ---- capture_check_sva.sv ----
// Assertions on the input capture channel ports
`timescale 1ns/10ps
module capture_check #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Register port
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [15:0] rdata,
    // Pin and interrupt
    input wire logic        capture_input_pin,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd(logic [3:0] a);
        rd_en && addr == a;
    endsequence
    sequence s_wr_off;
        wr_en && addr == 4'h0 && wdata[2:0] == 3'h0;
    endsequence
    sequence s_quiet_st;
        rd_en && addr == 4'h2 && $stable(capture_input_pin);
    endsequence
    a_rdata_idle_zero: assert property (!rd_en |=> rdata == 16'h0000)
        else $error("read data not zero outside read");
    a_unmapped_read: assert property (rd_en && addr > 4'h3 |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_status_upper_zero: assert property (s_rd(4'h2) |=> rdata[15:3] == 13'h0000)
        else $error("status upper bits set");
    a_ctrl_write_back: assert property (s_wr_off ##2 s_rd(4'h0) |=>
        rdata == ($past(wdata, 3) & capture_pkg::CONTROL_WRITE_MASK))
        else $error("control readback wrong");
    a_mask_write_back: assert property (wr_en && addr == 4'h3 ##2 s_rd(4'h3) |=>
        rdata == ($past(wdata, 3) & 16'h0007))
        else $error("mask readback wrong");
    a_mask_zero_quiet: assert property (wr_en && addr == 4'h3 && wdata == 16'h0000 |=> !irq)
        else $error("irq with zero mask");
    a_irq_low_release: assert property ($rose(reset_n) |-> !irq)
        else $error("irq high after reset");
    a_status_read_clears: assert property (s_quiet_st ##1 $stable(capture_input_pin)
        ##1 s_quiet_st |=> rdata == 16'h0000)
        else $error("status not cleared by read");
endmodule

bind input_capture_channel capture_check #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_check (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .capture_input_pin(capture_input_pin), .irq(irq)
);

// ---- capture_pkg.sv ----
// Constants shared by the input capture channel
package capture_pkg;

    // Register map, word offsets on the plain register port
    localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
    localparam logic [3:0] ADDR_BUFFER      = 4'h1;
    localparam logic [3:0] ADDR_INT_STATUS  = 4'h2;
    localparam logic [3:0] ADDR_INT_MASK    = 4'h3;

    // Field positions in capture_control_one
    localparam int IDLE_STOP_BIT   = 13;
    localparam int TBSEL_LSB       = 10;
    localparam int CPI_LSB         = 5;
    localparam int OVF_BIT         = 4;
    localparam int BNE_BIT         = 3;
    localparam int MODE_LSB        = 0;

    // Writable bits of capture_control_one
    localparam logic [15:0] CONTROL_WRITE_MASK = 16'h3c67;
    localparam logic [15:0] CONTROL_RESET      = 16'h0000;

    // Interrupt status bits
    localparam int IRQ_CAPTURE_BIT  = 0;
    localparam int IRQ_OVERFLOW_BIT = 1;
    localparam int IRQ_WAKE_BIT     = 2;

    // Time base select codes
    localparam logic [2:0] TB_TIMER3 = 3'h0;
    localparam logic [2:0] TB_TIMER2 = 3'h1;
    localparam logic [2:0] TB_TIMER4 = 3'h2;
    localparam logic [2:0] TB_TIMER5 = 3'h3;
    localparam logic [2:0] TB_TIMER1 = 3'h4;
    localparam logic [2:0] TB_SYSCLK = 3'h7;

    // Capture modes
    localparam logic [2:0] MODE_OFF     = 3'h0;
    localparam logic [2:0] MODE_BOTH    = 3'h1;
    localparam logic [2:0] MODE_FALL    = 3'h2;
    localparam logic [2:0] MODE_RISE    = 3'h3;
    localparam logic [2:0] MODE_PRE4    = 3'h4;
    localparam logic [2:0] MODE_PRE16   = 3'h5;
    localparam logic [2:0] MODE_UNUSED  = 3'h6;
    localparam logic [2:0] MODE_WAKE    = 3'h7;

    // Prescale terminal counts
    localparam logic [3:0] PRE4_LAST    = 4'h3;
    localparam logic [3:0] PRE16_LAST   = 4'hf;

    localparam int FIFO_DEPTH = 4;
endpackage

// ---- input_capture_channel.sv ----
// Input capture channel with control register, buffer and interrupt
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps

// Summary of operation
// - Idle stop bit halts channel in Idle
// - Time base select picks captured counter
// - Interrupt every capture, or every second, third, fourth capture
// - Mode 111 rising-edge wake interrupt only
// - Modes 000 and 110 disable channel
// - Mode 010 captures falling edges
// - Mode 001 both edges, interrupt each
module input_capture_channel #(
    parameter int WIDTH = 16,
    parameter int DEPTH = capture_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Register port
    input  wire logic [3:0]       addr,
    input  wire logic [15:0]      wdata,
    input  wire logic             wr_en,
    input  wire logic             rd_en,
    output      logic [15:0]      rdata,
    // Power state of the processor
    input  wire logic             cpu_idle,
    input  wire logic             cpu_sleep,
    // Time bases
    input  wire logic [WIDTH-1:0] sys_count,
    input  wire logic [WIDTH-1:0] timer1_count,
    input  wire logic [WIDTH-1:0] timer2_count,
    input  wire logic [WIDTH-1:0] timer3_count,
    input  wire logic [WIDTH-1:0] timer4_count,
    input  wire logic [WIDTH-1:0] timer5_count,
    // Capture pin
    input  wire logic             capture_input_pin,
    // Interrupt
    output      logic             irq
);
    typedef enum logic [1:0] {CPI_ONE, CPI_TWO, CPI_THREE, CPI_FOUR} cpi_t;

    capture_buf_if #(.WIDTH(WIDTH)) buf_bus ();

    capture_buffer #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_buffer (
        .clk     (clk),
        .reset_n (reset_n),
        .bus     (buf_bus)
    );

    // Control fields
    logic [15:0] control_bits;
    logic        capture_overflow_flag;
    logic        pin_prev;
    logic [3:0]  prescale;
    logic [1:0]  cap_count;
    logic [2:0]  int_status;
    logic [2:0]  int_mask;
    logic        read_pending;
    logic [15:0] read_word;

    wire       idle_stop_select       = control_bits[capture_pkg::IDLE_STOP_BIT];
    wire [2:0] time_base_select       = control_bits[capture_pkg::TBSEL_LSB +: 3];
    wire [1:0] captures_per_interrupt = control_bits[capture_pkg::CPI_LSB +: 2];
    wire [2:0] capture_mode_select    = control_bits[capture_pkg::MODE_LSB +: 3];
    wire       buffer_not_empty_flag  = buf_bus.not_empty;

    // Channel enable and halt
    wire halted  = idle_stop_select && cpu_idle;
    wire mode_on = (capture_mode_select != capture_pkg::MODE_OFF)
                && (capture_mode_select != capture_pkg::MODE_UNUSED)
                && (capture_mode_select != capture_pkg::MODE_WAKE);
    wire run     = mode_on && !halted;

    // Edge detection
    wire rise_edge = capture_input_pin && !pin_prev;
    wire fall_edge = !capture_input_pin && pin_prev;

    // Time base selection
    function automatic logic [WIDTH-1:0] pick_base(input logic [2:0] sel);
        case (sel)
            capture_pkg::TB_SYSCLK: pick_base = sys_count;
            capture_pkg::TB_TIMER1: pick_base = timer1_count;
            capture_pkg::TB_TIMER5: pick_base = timer5_count;
            capture_pkg::TB_TIMER4: pick_base = timer4_count;
            capture_pkg::TB_TIMER2: pick_base = timer2_count;
            capture_pkg::TB_TIMER3: pick_base = timer3_count;
            default:                pick_base = '0;
        endcase
    endfunction

    wire [WIDTH-1:0] base_value = pick_base(time_base_select);

    // Capture event per mode
    logic capture_event;
    always_comb
    begin
        case (capture_mode_select)
            capture_pkg::MODE_BOTH:  capture_event = rise_edge || fall_edge;
            capture_pkg::MODE_FALL:  capture_event = fall_edge;
            capture_pkg::MODE_RISE:  capture_event = rise_edge;
            capture_pkg::MODE_PRE4:  capture_event = rise_edge
                                      && ((prescale & capture_pkg::PRE4_LAST)
                                          == capture_pkg::PRE4_LAST);
            capture_pkg::MODE_PRE16: capture_event = rise_edge
                                      && (prescale == capture_pkg::PRE16_LAST);
            default:                 capture_event = 1'b0;
        endcase
    end

    wire capture = run && capture_event;

    // Interrupt division
    wire [1:0] cpi_last = (capture_mode_select == capture_pkg::MODE_BOTH)
                        ? 2'(CPI_ONE) : captures_per_interrupt;
    wire capture_irq_event = capture && (cap_count == cpi_last);

    // Wake interrupt on rising edge in Sleep or Idle
    wire wake_event = (capture_mode_select == capture_pkg::MODE_WAKE)
                   && (cpu_sleep || cpu_idle) && rise_edge;

    wire overflow_event = capture && buf_bus.full;

    // Buffer connections
    wire read_buffer = rd_en && (addr == capture_pkg::ADDR_BUFFER);
    assign buf_bus.push      = capture && !buf_bus.full;
    assign buf_bus.push_data = base_value;
    assign buf_bus.pop       = read_buffer;
    assign buf_bus.clear     = !mode_on && (capture_mode_select != capture_pkg::MODE_WAKE);

    // Register decode
    wire write_control = wr_en && (addr == capture_pkg::ADDR_CONTROL_ONE);
    wire write_mask    = wr_en && (addr == capture_pkg::ADDR_INT_MASK);
    wire read_status   = rd_en && (addr == capture_pkg::ADDR_INT_STATUS);

    wire [15:0] control_view = (control_bits & capture_pkg::CONTROL_WRITE_MASK)
                             | (16'(capture_overflow_flag) << capture_pkg::OVF_BIT)
                             | (16'(buffer_not_empty_flag) << capture_pkg::BNE_BIT);

    wire [2:0] new_events;
    assign new_events[capture_pkg::IRQ_CAPTURE_BIT]  = capture_irq_event;
    assign new_events[capture_pkg::IRQ_OVERFLOW_BIT] = overflow_event;
    assign new_events[capture_pkg::IRQ_WAKE_BIT]     = wake_event;

    logic [15:0] next_read_word;
    always_comb
    begin
        case (addr)
            capture_pkg::ADDR_CONTROL_ONE: next_read_word = control_view;
            capture_pkg::ADDR_BUFFER:      next_read_word = 16'(buf_bus.head);
            capture_pkg::ADDR_INT_STATUS:  next_read_word = 16'(int_status);
            capture_pkg::ADDR_INT_MASK:    next_read_word = 16'(int_mask);
            default:                       next_read_word = 16'h0000;
        endcase
    end

    assign rdata = read_pending ? read_word : 16'h0000;
    assign irq   = |(int_status & int_mask);

    // Control register, software fields only
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            control_bits <= capture_pkg::CONTROL_RESET;
        else if (write_control)
            control_bits <= wdata & capture_pkg::CONTROL_WRITE_MASK;
    end

    // Overflow flag, cleared when the channel is turned off
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            capture_overflow_flag <= 1'b0;
        else if (overflow_event)
            capture_overflow_flag <= 1'b1;
        else if (buf_bus.clear)
            capture_overflow_flag <= 1'b0;
    end

    // Pin history, prescaler and capture counter
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_prev  <= 1'b0;
            prescale  <= 4'h0;
            cap_count <= 2'h0;
        end
        else
        begin
            pin_prev <= capture_input_pin;
            if (!mode_on)
            begin
                prescale  <= 4'h0;
                cap_count <= 2'h0;
            end
            else if (!halted)
            begin
                if (rise_edge)
                    prescale <= prescale + 4'h1;
                if (capture)
                    cap_count <= (cap_count == cpi_last) ? 2'h0 : cap_count + 2'h1;
            end
        end
    end

    // Interrupt status, set wins over clear on read
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            int_status <= 3'h0;
        else
            int_status <= (read_status ? 3'h0 : int_status) | new_events;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            int_mask <= 3'h0;
        else if (write_mask)
            int_mask <= wdata[2:0];
    end

    // Read data register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_pending <= 1'b0;
            read_word    <= 16'h0000;
        end
        else
        begin
            read_pending <= rd_en;
            read_word    <= rd_en ? next_read_word : 16'h0000;
        end
    end
endmodule

// ---- input_capture_channel_tb.sv ----
// Self-checking bench for the input capture channel
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module input_capture_channel_tb;
    logic        clk       = 1'b0;
    logic        reset_n   = 1'b0;
    logic [3:0]  addr      = 4'h0;
    logic [15:0] wdata     = 16'h0000;
    logic        wr_en     = 1'b0;
    logic        rd_en     = 1'b0;
    logic        cpu_idle  = 1'b0;
    logic        cpu_sleep = 1'b0;
    logic        want      = 1'b0;
    logic        slow      = 1'b0;
    logic        pend      = 1'b0;
    logic [15:0] tb_v [8]  = '{default: 16'h0000};
    int          ncap [7]  = '{0, 32, 16, 16, 4, 1, 0};
    logic [15:0] rdata;
    logic        pin;
    logic        irq;
    logic [15:0] exp_q [$];
    logic [15:0] mon_e;
    logic [15:0] v;
    int          n;
    int          err_count = 0;
    int          checked   = 0;

    initial forever #12.5 clk = ~clk;

    input_capture_channel uut (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
        .sys_count(tb_v[7]), .timer1_count(tb_v[4]), .timer2_count(tb_v[1]),
        .timer3_count(tb_v[0]), .timer4_count(tb_v[2]), .timer5_count(tb_v[3]),
        .capture_input_pin(pin), .irq(irq)
    );
    pin_source src (.clk(clk), .want(want), .slow(slow), .pin(pin));

    // Read results are compared against the oldest note
    always @(posedge clk) pend <= rd_en;
    always @(negedge clk)
        if (pend)
        begin
            mon_e = exp_q.pop_front();
            `CHK(rdata, mon_e)
        end

    task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= ~w;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask
    task half(input logic lvl);
        want <= lvl;
        repeat (4) @(posedge clk);
    endtask
    task pulse;
        half(1'b1);
        half(1'b0);
    endtask
    task irq_is(input logic e);
        @(negedge clk);
        `CHK(irq, e)
        @(posedge clk);
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("BAD %0t run too long", $time);
        print_verdict;
    end

    initial
    begin
        void'($urandom(97));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            tb_v[i] <= 16'($urandom);
        @(posedge clk);
        rd(4'h0, capture_pkg::CONTROL_RESET);
        rd(4'h2, 16'h0000);
        rd(4'h9, 16'h0000);
        v = 16'($urandom) & 16'hfff8;
        bus(1'b1, 4'h0, v);
        rd(4'h0, v & 16'h3c60);
        bus(1'b1, 4'h3, 16'h0007);
        rd(4'h3, 16'h0007);
        $display("done registers");
        for (int t = 0; t < 8; t++)
        begin
            v = (t == 5 || t == 6) ? 16'h0000 : tb_v[t];
            bus(1'b1, 4'h0, 16'h0000);
            bus(1'b1, 4'h0, 16'(t << 10) | 16'h0003);
            pulse;
            rd(4'h0, 16'(t << 10) | 16'h000b);
            rd(4'h1, v);
            rd(4'h0, 16'(t << 10) | 16'h0003);
            rd(4'h2, 16'h0001);
            rd(4'h2, 16'h0000);
        end
        $display("done time base");
        for (int m = 0; m < 7; m++)
        begin
            n = ncap[m];
            slow <= m[0];
            bus(1'b1, 4'h0, 16'h0000);
            bus(1'b1, 4'h0, 16'(m));
            repeat (16) pulse;
            v = (n > 4) ? 16'h0010 : 16'h0000;
            rd(4'h0, 16'(m) | v | ((n > 0) ? 16'h0008 : 16'h0000));
            rd(4'h2, (v >> 3) | 16'(n > 0));
            for (int i = 0; i < n && i < 4; i++)
                rd(4'h1, tb_v[0]);
            rd(4'h0, 16'(m) | v);
        end
        $display("done modes");
        slow <= 1'b0;
        bus(1'b1, 4'h3, 16'h0001);
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, 4'h0, 16'h0000);
            bus(1'b1, 4'h0, 16'(c << 5) | 16'h0003);
            for (int p = 1; p < 5; p++)
            begin
                pulse;
                irq_is(p % (c + 1) == 0);
                rd(4'h2, 16'(p % (c + 1) == 0));
            end
        end
        bus(1'b1, 4'h0, 16'h0000);
        bus(1'b1, 4'h0, 16'h0061);
        half(1'b1);
        irq_is(1'b1);
        rd(4'h2, 16'h0001);
        half(1'b0);
        rd(4'h2, 16'h0001);
        bus(1'b1, 4'h3, 16'h0000);
        pulse;
        irq_is(1'b0);
        rd(4'h2, 16'h0001);
        $display("done interrupts");
        cpu_idle <= 1'b1;
        bus(1'b1, 4'h0, 16'h0000);
        bus(1'b1, 4'h0, 16'h2003);
        pulse;
        rd(4'h0, 16'h2003);
        bus(1'b1, 4'h0, 16'h0003);
        pulse;
        rd(4'h0, 16'h000b);
        rd(4'h2, 16'h0001);
        cpu_idle <= 1'b0;
        bus(1'b1, 4'h0, 16'h0000);
        bus(1'b1, 4'h0, 16'h0007);
        cpu_sleep <= 1'b1;
        pulse;
        rd(4'h2, 16'h0004);
        cpu_sleep <= 1'b0;
        pulse;
        rd(4'h2, 16'h0000);
        rd(4'h0, 16'h0007);
        $display("done power");
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0)
            err_count++;
        print_verdict;
    end
endmodule

// ---- pin_source.sv ----
// Behavioural source driving the capture input pin
`timescale 1ns/10ps
module pin_source (
    // Clock
    input  wire logic clk,
    // Control from the bench
    input  wire logic want,
    input  wire logic slow,
    // Driven pin
    output wire logic pin
);
    logic [1:0] lag   = 2'h0;
    logic       pin_q = 1'b0;
    assign pin = pin_q;
    // Slow answer adds two cycles of lag
    always @(posedge clk)
    begin
        lag   <= {lag[0], want};
        pin_q <= slow ? lag[1] : want;
    end
endmodule
